// file: hdl/cst_exec.v
// execute unit for the compact subtract, trap, extend and bit-test instructions
`timescale 1ns/1ns
`include "cst_defs.vh"
module cst_exec (
	clk,
	rst_b,
	ce,
	instr_valid,
	instr,
	instr_pc,
	exec_done,
	undef_instr,
	pc_load,
	pc_target,
	status_out,
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hwdata,
	hready,
	hrdata,
	hreadyout,
	hresp
);
	input wire clk;
	input wire rst_b;
	input wire ce;
	input wire instr_valid;
	input wire [15:0] instr;
	input wire [31:0] instr_pc;
	output reg exec_done;
	output reg undef_instr;
	output reg pc_load;
	output reg [31:0] pc_target;
	output reg [31:0] status_out;
	input wire hsel;
	input wire [31:0] haddr;
	input wire [1:0] htrans;
	input wire hwrite;
	input wire [2:0] hsize;
	input wire [31:0] hwdata;
	input wire hready;
	output reg [31:0] hrdata;
	output reg hreadyout;
	output reg hresp;

	// ==========================================
	// architectural state
	reg [31:0] gpr [0:7];
	reg [31:0] stack_ptr;
	reg [31:0] current_status_word;
	reg [31:0] supervisor_link_register;
	reg [31:0] supervisor_saved_status;
	reg [`CST_CTRL_WIDTH-1:0] ctrl;

	wire [1:0] arch;
	wire high_vectors;
	wire exception_endian_bit;
	assign arch = ctrl[`CST_CTRL_ARCH_HI:`CST_CTRL_ARCH_LO];
	assign high_vectors = ctrl[`CST_CTRL_HIVEC];
	assign exception_endian_bit = ctrl[`CST_CTRL_EE];

	// ==========================================
	// decode
	wire is_sub_reg;
	wire is_sub_sp;
	wire is_trap;
	wire is_sign_extend_byte_instr;
	wire is_sign_extend_half_instr;
	wire is_zero_extend_byte_instr;
	wire is_zero_extend_half_instr;
	wire is_tst;
	wire is_undef;
	wire [2:0] rd;
	wire [2:0] rn;
	wire [2:0] rm;
	wire [6:0] imm7;

	cst_decode u_decode (
		.instr(instr),
		.arch(arch),
		.is_sub_reg(is_sub_reg),
		.is_sub_sp(is_sub_sp),
		.is_trap(is_trap),
		.is_sign_extend_byte_instr(is_sign_extend_byte_instr),
		.is_sign_extend_half_instr(is_sign_extend_half_instr),
		.is_zero_extend_byte_instr(is_zero_extend_byte_instr),
		.is_zero_extend_half_instr(is_zero_extend_half_instr),
		.is_tst(is_tst),
		.is_undef(is_undef),
		.rd(rd),
		.rn(rn),
		.rm(rm),
		.imm7(imm7)
	);

	// ==========================================
	// datapath
	wire [31:0] first_operand_reg;
	wire [31:0] second_operand_reg;
	wire [31:0] sp_decrement;
	wire [31:0] alu_a;
	wire [31:0] alu_b;
	wire [31:0] alu_res;
	wire alu_n;
	wire alu_z;
	wire alu_c;
	wire alu_v;

	assign first_operand_reg = gpr[rn];
	assign second_operand_reg = gpr[rm];
	// immediate times four, 0 to 508
	assign sp_decrement = {23'h000000, imm7, 2'h0};
	assign alu_a = is_sub_sp ? stack_ptr : first_operand_reg;
	assign alu_b = is_sub_sp ? sp_decrement : second_operand_reg;

	cst_alu u_alu (
		.op_a(alu_a),
		.op_b(alu_b),
		.sel_and(is_tst),
		.result(alu_res),
		.flag_n(alu_n),
		.flag_z(alu_z),
		.flag_c(alu_c),
		.flag_v(alu_v)
	);

	// ==========================================
	// next state of the executed instruction
	reg next_gpr_we;
	reg [31:0] next_gpr_val;
	reg next_sp_we;
	reg [31:0] next_status;
	reg next_trap;
	reg [31:0] trap_status;
	reg [31:0] ext_val;

	always @* begin
		ext_val = second_operand_reg;
		if (is_sign_extend_byte_instr) begin
			ext_val = {{24{second_operand_reg[7]}}, second_operand_reg[7:0]};
		end else if (is_sign_extend_half_instr) begin
			ext_val = {{16{second_operand_reg[15]}}, second_operand_reg[15:0]};
		end else if (is_zero_extend_byte_instr) begin
			ext_val = {24'h000000, second_operand_reg[7:0]};
		end else if (is_zero_extend_half_instr) begin
			ext_val = {16'h0000, second_operand_reg[15:0]};
		end
	end

	always @* begin
		trap_status = current_status_word;
		trap_status[`CST_SW_MODE_HI:`CST_SW_MODE_LO] = `CST_MODE_SVC;
		trap_status[`CST_SW_T] = 1'b0;
		trap_status[`CST_SW_I] = 1'b1;
		trap_status[`CST_SW_E] = exception_endian_bit;
	end

	always @* begin
		next_gpr_we = 1'b0;
		next_gpr_val = alu_res;
		next_sp_we = 1'b0;
		next_status = current_status_word;
		next_trap = 1'b0;
		if (instr_valid) begin
			if (is_sub_reg) begin
				next_gpr_we = 1'b1;
				next_status[`CST_SW_N] = alu_n;
				next_status[`CST_SW_Z] = alu_z;
				next_status[`CST_SW_C] = alu_c;
				next_status[`CST_SW_V] = alu_v;
			end else if (is_sub_sp) begin
				// flags kept as they were
				next_sp_we = 1'b1;
			end else if (is_trap) begin
				next_trap = 1'b1;
				next_status = trap_status;
			end else if (is_tst) begin
				// no register write, C and V kept
				next_status[`CST_SW_N] = alu_n;
				next_status[`CST_SW_Z] = alu_z;
			end else if (is_sign_extend_byte_instr || is_sign_extend_half_instr || is_zero_extend_byte_instr || is_zero_extend_half_instr) begin
				next_gpr_we = 1'b1;
				next_gpr_val = ext_val;
			end
		end
	end

	// ==========================================
	// bus slave address phase decode
	wire bus_take;
	wire [7:0] bus_word;
	reg wr_pend;
	reg [7:0] wr_addr;

	assign bus_take = hsel && htrans[1] && hready;
	assign bus_word = {haddr[`CST_ADDR_HI:2], 2'h0};

	function writable;
		input [7:0] a;
		begin
			writable = (a == `CST_REG_CTRL) || (a == `CST_REG_STATUS) ||
				(a == `CST_REG_SP) || (a[7:5] == `CST_GPR_PAGE);
		end
	endfunction

	reg [31:0] rd_word;
	always @* begin
		rd_word = `CST_RST_WORD;
		if (bus_word[7:5] == `CST_GPR_PAGE) begin
			rd_word = gpr[bus_word[4:2]];
		end else begin
			case (bus_word)
				`CST_REG_CTRL: rd_word = {28'h0000000, ctrl};
				`CST_REG_STATUS: rd_word = current_status_word;
				`CST_REG_SUP_LINK: rd_word = supervisor_link_register;
				`CST_REG_SUP_SAVED: rd_word = supervisor_saved_status;
				`CST_REG_SP: rd_word = stack_ptr;
				default: rd_word = `CST_RST_WORD;
			endcase
		end
		if (wr_pend && (wr_addr == bus_word) && writable(bus_word)) begin
			rd_word = hwdata;
		end
	end

	// ==========================================
	// state update
	integer i;
	always @(posedge clk) begin
		if (!rst_b) begin
			for (i = 0; i < 8; i = i + 1) begin
				gpr[i] <= `CST_RST_WORD;
			end
			stack_ptr <= `CST_RST_WORD;
			current_status_word <= `CST_RST_STATUS;
			supervisor_link_register <= `CST_RST_WORD;
			supervisor_saved_status <= `CST_RST_WORD;
			ctrl <= `CST_RST_CTRL;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= `CST_RST_WORD;
			hreadyout <= 1'b1;
			hresp <= `CST_HRESP_OKAY;
			exec_done <= 1'b0;
			undef_instr <= 1'b0;
			pc_load <= 1'b0;
			pc_target <= `CST_RST_WORD;
			status_out <= `CST_RST_STATUS;
		end else if (ce) begin
			hreadyout <= 1'b1;
			hresp <= `CST_HRESP_OKAY;
			wr_pend <= bus_take && hwrite;
			wr_addr <= bus_word;
			if (bus_take && !hwrite) begin
				hrdata <= rd_word;
			end
			// bus data phase write; a same-cycle instruction overrides below
			if (wr_pend) begin
				if (wr_addr[7:5] == `CST_GPR_PAGE) begin
					gpr[wr_addr[4:2]] <= hwdata;
				end else begin
					case (wr_addr)
						`CST_REG_CTRL: ctrl <= hwdata[`CST_CTRL_WIDTH-1:0];
						`CST_REG_STATUS: current_status_word <= hwdata;
						`CST_REG_SP: stack_ptr <= hwdata;
						default: ctrl <= ctrl;
					endcase
				end
			end
			if (next_gpr_we) begin
				gpr[rd] <= next_gpr_val;
			end
			if (next_sp_we) begin
				stack_ptr <= alu_res;
			end
			if (instr_valid && !is_undef) begin
				current_status_word <= next_status;
			end
			if (next_trap) begin
				supervisor_link_register <= instr_pc + `CST_INSTR_BYTES;
				supervisor_saved_status <= current_status_word;
				pc_target <= high_vectors ? `CST_VEC_TRAP_HI : `CST_VEC_TRAP_LO;
			end
			pc_load <= next_trap;
			exec_done <= instr_valid;
			undef_instr <= instr_valid && is_undef;
			status_out <= (instr_valid && !is_undef) ? next_status
				: (wr_pend && (wr_addr == `CST_REG_STATUS)) ? hwdata : current_status_word;
		end
	end
endmodule

// file: hdl/cst_defs.vh
// constants for the compact subtract, trap, extend and bit-test execute block
// Function
// - register subtract writes first minus second operand, sets N Z C(not borrow) V
// - stack adjust subtracts seven-bit immediate times four from stack pointer
// - stack adjust leaves all four condition flags unchanged
// - trap service number in bits 7..0 is ignored by execution
// - trap loads supervisor link with next address, saves status word
// - trap sets mode field bits 4..0 to supervisor code 10011
// - trap clears status bit 5, handler runs in wide instruction state
// - trap sets status bit 7, masking normal interrupts
// - trap keeps bits 6 and 8, loads bit 9 from exception endian bit
// - trap branches to offset 8, high or low vector base
// - byte sign extend widens low 8 bits to 32, flags untouched
// - halfword sign extend widens low 16 bits to 32, flags untouched
// - bit test ANDs both operands for flags only, writes no register
// - bit test sets N from bit 31, Z on zero, keeps C and V
// - byte zero extend writes low eight bits, upper bits cleared
// - halfword zero extend writes low sixteen bits, upper bits cleared
// - subtract, trap, bit test in all versions; extends only from version 6
`ifndef CST_DEFS_VH
`define CST_DEFS_VH

// ==========================================
// opcode patterns and masks
`define CST_MASK_SUB_REG 16'hfe00
`define CST_PAT_SUB_REG 16'h1a00
`define CST_MASK_SUB_SP 16'hff80
`define CST_PAT_SUB_SP 16'hb080
`define CST_MASK_TRAP 16'hff00
`define CST_PAT_TRAP 16'hdf00
`define CST_MASK_EXT 16'hffc0
`define CST_PAT_SIGN_EXTEND_BYTE_INSTR 16'hb240
`define CST_PAT_SIGN_EXTEND_HALF_INSTR 16'hb200
`define CST_PAT_ZERO_EXTEND_BYTE_INSTR 16'hb2c0
`define CST_PAT_ZERO_EXTEND_HALF_INSTR 16'hb280
`define CST_PAT_TST 16'h4200

// ==========================================
// instruction fields
`define CST_F_RD_HI 2
`define CST_F_RD_LO 0
`define CST_F_RN3_HI 5
`define CST_F_RN3_LO 3
`define CST_F_RM3_HI 8
`define CST_F_RM3_LO 6
`define CST_F_IMM7_HI 6
`define CST_F_IMM7_LO 0
`define CST_SP_SHIFT 2
`define CST_INSTR_BYTES 32'h00000002

// ==========================================
// status word layout
`define CST_SW_N 31
`define CST_SW_Z 30
`define CST_SW_C 29
`define CST_SW_V 28
`define CST_SW_UPPER_HI 27
`define CST_SW_UPPER_LO 10
`define CST_SW_E 9
`define CST_SW_A 8
`define CST_SW_I 7
`define CST_SW_F 6
`define CST_SW_T 5
`define CST_SW_MODE_HI 4
`define CST_SW_MODE_LO 0
`define CST_MODE_SVC 5'h13

// ==========================================
// vectors and versions
`define CST_VEC_TRAP_HI 32'hffff0008
`define CST_VEC_TRAP_LO 32'h00000008
`define CST_ARCH_V4T 2'h0
`define CST_ARCH_V5T 2'h1
`define CST_ARCH_V6 2'h2

// ==========================================
// register map, byte addresses
`define CST_ADDR_HI 7
`define CST_REG_CTRL 8'h00
`define CST_REG_STATUS 8'h04
`define CST_REG_SUP_LINK 8'h08
`define CST_REG_SUP_SAVED 8'h0c
`define CST_REG_SP 8'h10
`define CST_GPR_PAGE 3'h1
`define CST_CTRL_ARCH_HI 1
`define CST_CTRL_ARCH_LO 0
`define CST_CTRL_HIVEC 2
`define CST_CTRL_EE 3
`define CST_CTRL_WIDTH 4
`define CST_RST_CTRL 4'h2
`define CST_RST_STATUS 32'h00000033
`define CST_RST_WORD 32'h00000000
`define CST_HRESP_OKAY 1'b0

`endif

// file: hdl/cst_alu.v
// subtract and and datapath with condition flags
`timescale 1ns/1ns
module cst_alu (
	op_a,
	op_b,
	sel_and,
	result,
	flag_n,
	flag_z,
	flag_c,
	flag_v
);
	input wire [31:0] op_a;
	input wire [31:0] op_b;
	input wire sel_and;
	output wire [31:0] result;
	output wire flag_n;
	output wire flag_z;
	output wire flag_c;
	output wire flag_v;

	wire [32:0] diff;
	assign diff = {1'b0, op_a} + {1'b0, ~op_b} + 33'h000000001;
	assign result = sel_and ? (op_a & op_b) : diff[31:0];
	assign flag_n = result[31];
	assign flag_z = (result == 32'h00000000);
	assign flag_c = diff[32];
	assign flag_v = (op_a[31] != op_b[31]) && (diff[31] != op_a[31]);
endmodule

// file: hdl/cst_decode.v
// opcode decode and version gating
`timescale 1ns/1ns
`include "cst_defs.vh"
module cst_decode (
	instr,
	arch,
	is_sub_reg,
	is_sub_sp,
	is_trap,
	is_sign_extend_byte_instr,
	is_sign_extend_half_instr,
	is_zero_extend_byte_instr,
	is_zero_extend_half_instr,
	is_tst,
	is_undef,
	rd,
	rn,
	rm,
	imm7
);
	input wire [15:0] instr;
	input wire [1:0] arch;
	output wire is_sub_reg;
	output wire is_sub_sp;
	output wire is_trap;
	output wire is_sign_extend_byte_instr;
	output wire is_sign_extend_half_instr;
	output wire is_zero_extend_byte_instr;
	output wire is_zero_extend_half_instr;
	output wire is_tst;
	output wire is_undef;
	output wire [2:0] rd;
	output wire [2:0] rn;
	output wire [2:0] rm;
	output wire [6:0] imm7;

	function match;
		input [15:0] word;
		input [15:0] mask;
		input [15:0] pat;
		begin
			match = ((word & mask) == pat);
		end
	endfunction

	wire ext_ok;
	wire raw_sign_extend_byte_instr;
	wire raw_sign_extend_half_instr;
	wire raw_zero_extend_byte_instr;
	wire raw_zero_extend_half_instr;
	wire tst_form;

	// extends only from version 6
	assign ext_ok = (arch == `CST_ARCH_V6);
	assign raw_sign_extend_byte_instr = match(instr, `CST_MASK_EXT, `CST_PAT_SIGN_EXTEND_BYTE_INSTR);
	assign raw_sign_extend_half_instr = match(instr, `CST_MASK_EXT, `CST_PAT_SIGN_EXTEND_HALF_INSTR);
	assign raw_zero_extend_byte_instr = match(instr, `CST_MASK_EXT, `CST_PAT_ZERO_EXTEND_BYTE_INSTR);
	assign raw_zero_extend_half_instr = match(instr, `CST_MASK_EXT, `CST_PAT_ZERO_EXTEND_HALF_INSTR);
	assign tst_form = match(instr, `CST_MASK_EXT, `CST_PAT_TST);

	assign is_sub_reg = match(instr, `CST_MASK_SUB_REG, `CST_PAT_SUB_REG);
	assign is_sub_sp = match(instr, `CST_MASK_SUB_SP, `CST_PAT_SUB_SP);
	// only the top byte decides, service number is left alone
	assign is_trap = match(instr, `CST_MASK_TRAP, `CST_PAT_TRAP);
	assign is_tst = tst_form;
	assign is_sign_extend_byte_instr = raw_sign_extend_byte_instr && ext_ok;
	assign is_sign_extend_half_instr = raw_sign_extend_half_instr && ext_ok;
	assign is_zero_extend_byte_instr = raw_zero_extend_byte_instr && ext_ok;
	assign is_zero_extend_half_instr = raw_zero_extend_half_instr && ext_ok;
	assign is_undef = (raw_sign_extend_byte_instr || raw_sign_extend_half_instr || raw_zero_extend_byte_instr || raw_zero_extend_half_instr) && !ext_ok;

	// low register indices; bit test puts first operand in the low field
	assign rd = instr[`CST_F_RD_HI:`CST_F_RD_LO];
	assign rn = tst_form ? instr[`CST_F_RD_HI:`CST_F_RD_LO]
		: instr[`CST_F_RN3_HI:`CST_F_RN3_LO];
	assign rm = (is_sub_reg) ? instr[`CST_F_RM3_HI:`CST_F_RM3_LO]
		: instr[`CST_F_RN3_HI:`CST_F_RN3_LO];
	assign imm7 = instr[`CST_F_IMM7_HI:`CST_F_IMM7_LO];
endmodule

// file: tb/cst_exec_sva.sv
// assertion checker for the compact execute block
`timescale 1ns/1ns
module cst_exec_sva (
	input wire clk,
	input wire rst_b,
	input wire ce,
	input wire instr_valid,
	input wire [15:0] instr,
	input wire exec_done,
	input wire pc_load,
	input wire [31:0] pc_target,
	input wire [31:0] status_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ==========================================
	// sequences
	sequence s_trap;
		ce && instr_valid && instr[15:8] == 8'hdf;
	endsequence
	sequence s_keep;
		ce && instr_valid && (instr[15:7] == 9'h161 || instr[15:8] == 8'hb2);
	endsequence
	sequence s_tst;
		ce && instr_valid && instr[15:6] == 10'h108;
	endsequence
	// ==========================================
	// properties
	property p_done;
		exec_done == $past(ce && instr_valid);
	endproperty
	property p_load_only;
		pc_load |-> $past(ce && instr_valid && instr[15:8] == 8'hdf);
	endproperty
	property p_trap_load;
		s_trap |=> pc_load;
	endproperty
	property p_trap_mode;
		s_trap |=> status_out[4:0] == 5'h13;
	endproperty
	property p_trap_wide;
		s_trap |=> !status_out[5];
	endproperty
	property p_trap_mask;
		s_trap |=> status_out[7];
	endproperty
	property p_trap_keep;
		s_trap |=> {status_out[8], status_out[6]} == $past({status_out[8], status_out[6]});
	endproperty
	property p_trap_vec;
		s_trap |=> pc_target == 32'h00000008 || pc_target == 32'hffff0008;
	endproperty
	property p_flags_keep;
		s_keep |=> status_out[31:28] == $past(status_out[31:28]);
	endproperty
	property p_tst_cv;
		s_tst |=> status_out[29:28] == $past(status_out[29:28]);
	endproperty
	a_done: assert property (p_done) else $error("done pulse wrong");
	a_load_only: assert property (p_load_only) else $error("stray pc load");
	a_trap_load: assert property (p_trap_load) else $error("no pc load");
	a_trap_mode: assert property (p_trap_mode) else $error("mode wrong");
	a_trap_wide: assert property (p_trap_wide) else $error("state bit set");
	a_trap_mask: assert property (p_trap_mask) else $error("irq not masked");
	a_trap_keep: assert property (p_trap_keep) else $error("bits 6 8 moved");
	a_trap_vec: assert property (p_trap_vec) else $error("bad vector");
	a_flags_keep: assert property (p_flags_keep) else $error("flags moved");
	a_tst_cv: assert property (p_tst_cv) else $error("c v moved");
endmodule

bind cst_exec cst_exec_sva sva_u (.clk(clk), .rst_b(rst_b), .ce(ce),
	.instr_valid(instr_valid), .instr(instr), .exec_done(exec_done),
	.pc_load(pc_load), .pc_target(pc_target), .status_out(status_out));

// file: tb/testbench.sv
// self-checking bench for the compact execute block
`timescale 1ns/1ns
module testbench;
	reg clk = 1'b0;
	reg rst_b = 1'b0;
	reg instr_valid = 1'b0;
	reg [15:0] instr = 16'h0000;
	reg [31:0] instr_pc = 32'h00000000;
	reg [31:0] haddr = 32'h00000000;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg ce = 1'b1;
	reg [31:0] hwdata = 32'h00000000;
	wire exec_done, undef_instr, pc_load, hreadyout, hresp;
	wire [31:0] pc_target, status_out, hrdata;
	integer n_fail = 0;
	integer num_checks = 0;
	integer cyc = 0;
	reg [31:0] rd;
	reg und;
	reg ld;
	cst_exec dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .instr_valid(instr_valid),
		.instr(instr), .instr_pc(instr_pc), .exec_done(exec_done),
		.undef_instr(undef_instr), .pc_load(pc_load), .pc_target(pc_target),
		.status_out(status_out), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	initial begin
		forever #5 clk = ~clk;
	end
	// ==========================================
	// common tasks
	task end_sim;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task bus(input w, input [31:0] a, input [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge clk);
		while (!hreadyout) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (!hreadyout) @(posedge clk);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task rchk(input [31:0] a, input [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task exe(input [15:0] op, input [31:0] pc);
		instr_valid <= 1'b1;
		instr <= op;
		instr_pc <= pc;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		chk({31'h0, exec_done}, 32'h1);
		und = undef_instr;
		ld = pc_load;
		@(posedge clk);
	endtask
	// ==========================================
	// scenarios
	task t_reset;
		rchk(32'h0, 32'h2);
		rchk(32'h4, 32'h33);
		rchk(32'h40, 32'h0);
		bus(1'b1, 32'h8, 32'hdead0000);
		rchk(32'h8, 32'h0);
	endtask
	task t_sub(input [31:0] a, input [31:0] b);
		reg [31:0] r;
		r = a - b;
		bus(1'b1, 32'h24, a);
		bus(1'b1, 32'h28, b);
		exe(16'h1a8b, 32'h0);
		rchk(32'h2c, r);
		chk({28'h0, status_out[31:28]}, {28'h0, r[31], r == 0, a >= b, a[31] != b[31] && r[31] != a[31]});
	endtask
	task t_ce;
		bus(1'b1, 32'h2c, 32'h00000011);
		ce <= 1'b0;
		instr_valid <= 1'b1;
		instr <= 16'h1a8b;
		@(posedge clk);
		instr_valid <= 1'b0;
		ce <= 1'b1;
		#1;
		chk({31'h0, exec_done}, 32'h0);
		@(posedge clk);
		rchk(32'h2c, 32'h00000011);
	endtask
	task t_sp(input [6:0] k);
		bus(1'b1, 32'h10, 32'h1000);
		bus(1'b1, 32'h4, 32'hf0000033);
		exe({9'h161, k}, 32'h0);
		rchk(32'h10, 32'h1000 - {23'h0, k, 2'b00});
		chk(status_out, 32'hf0000033);
	endtask
	task t_ext(input [15:0] op, input [31:0] exp, input [1:0] arch);
		bus(1'b1, 32'h0, {30'h0, arch});
		bus(1'b1, 32'h38, 32'h0);
		bus(1'b1, 32'h34, 32'h123480f0);
		bus(1'b1, 32'h4, 32'h50000033);
		exe(op | 16'h002e, 32'h0);
		chk({31'h0, und}, {31'h0, arch != 2'h2});
		rchk(32'h38, arch == 2'h2 ? exp : 32'h0);
		chk(status_out, 32'h50000033);
	endtask
	task t_tst(input [31:0] a, input [31:0] b);
		reg [31:0] r;
		r = a & b;
		bus(1'b1, 32'h20, a);
		bus(1'b1, 32'h3c, b);
		bus(1'b1, 32'h4, 32'h30000033);
		exe(16'h4238, 32'h0);
		chk(status_out, {r[31], r == 0, 30'h30000033});
		rchk(32'h20, a);
		rchk(32'h3c, b);
	endtask
	task t_trap(input [3:0] c, input [15:0] op, input [31:0] pc);
		reg [31:0] s;
		s = 32'ha0000170;
		bus(1'b1, 32'h0, {28'h0, c});
		bus(1'b1, 32'h4, s);
		exe(op, pc);
		chk({31'h0, ld}, 32'h1);
		chk(pc_target, c[2] ? 32'hffff0008 : 32'h00000008);
		chk(status_out, s & ~32'h2bf | 32'h93 | {22'h0, c[3], 9'h0});
		rchk(32'h8, pc + 32'h2);
		rchk(32'hc, s);
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_reset;
		t_sub(32'h5, 32'h7);
		t_sub(32'h80000000, 32'h1);
		t_sub(32'h9, 32'h9);
		t_ce;
		t_sp(7'h7f);
		t_sp(7'h00);
		t_ext(16'hb240, 32'hfffffff0, 2'h2);
		t_ext(16'hb200, 32'hffff80f0, 2'h2);
		t_ext(16'hb2c0, 32'h000000f0, 2'h2);
		t_ext(16'hb280, 32'h000080f0, 2'h2);
		t_ext(16'hb240, 32'h0, 2'h0);
		t_ext(16'hb280, 32'h0, 2'h1);
		t_tst(32'h80000001, 32'h80000000);
		t_tst(32'hf0f0f0f0, 32'h0f0f0f0f);
		t_trap(4'he, 16'hdfa5, 32'h00001234);
		t_trap(4'h0, 16'hdf00, 32'h00000ffe);
		t_trap(4'h5, 16'hdfff, 32'h00002000);
		end_sim;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail = n_fail + 1;
			end_sim;
		end
	end
endmodule
